//--- inc/cvt_defines.svh
// register indices, field positions, reset values and counts
`ifndef CVT_DEFINES_SVH
`define CVT_DEFINES_SVH

`define CVT_IDX_CUR_HI 8'h0E
`define CVT_IDX_CUR_LO 8'h0F
`define CVT_IDX_VSS_LO 8'h10
`define CVT_IDX_VSE_CTL 8'h11
`define CVT_IDX_VDE_LO 8'h12
`define CVT_IDX_PITCH_LO 8'h13
`define CVT_IDX_UL_MODE 8'h14
`define CVT_IDX_VBS_LO 8'h15
`define CVT_IDX_TIMING_LAST 8'h07
`define CVT_IDX_OVERFLOW 8'h07

`define CVT_VSE_WPROT 7
`define CVT_VSE_REFRESH 6
`define CVT_VSE_IRQ_DIS 5
`define CVT_VSE_IRQ_CLR 4
`define CVT_UL_DWORD 6
`define CVT_UL_CNT4 5

`define CVT_REG_RESET 8'h00
`define CVT_RD_NONE 8'h00
`define CVT_MASK_ALL 8'hFF
`define CVT_MASK_LC8 8'h10

`define CVT_REFRESH_LO 3'h3
`define CVT_REFRESH_HI 3'h5
`define CVT_MA_DIV_LAST 2'h3
`define CVT_VSYNC_MAX_LINES 5'h10

`endif

//--- inc/cvt_pkg.sv
// types shared by the vertical timing and cursor block
package cvt_pkg;

    // fields held in neighbouring registers of the controller
    typedef struct packed {
        logic readback_en;
        logic [1:0] vss_hi;
        logic [1:0] vde_hi;
        logic vbs_b8;
        logic vbs_b9;
        logic [4:0] cell_height;
        logic byte_mode;
        logic pitch_b8;
        logic [15:0] start_addr;
        logic [9:0] vtotal;
    } cvt_ext_t;

    typedef struct packed {
        logic [7:0] cur_hi;
        logic [7:0] cur_lo;
        logic [7:0] vss_lo;
        logic [7:0] vse_ctl;
        logic [7:0] vde_lo;
        logic [7:0] pitch_lo;
        logic [7:0] ul_mode;
        logic [7:0] vbs_lo;
    } cvt_regs_t;

    typedef enum logic [1:0] {
        CVT_RF_IDLE = 2'b01,
        CVT_RF_RUN = 2'b10
    } cvt_rf_t;

    typedef struct packed {
        logic [7:0] idx;
        cvt_regs_t regs;
        logic [7:0] rdata;
        logic twr;
        logic [7:0] twr_idx;
        logic [7:0] twr_data;
        logic [7:0] twr_mask;
        logic hs_d;
        logic ch_d;
        logic [9:0] scan;
        logic [4:0] cell_row;
        logic [15:0] row_start;
        logic [15:0] ma_cnt;
        logic [1:0] ma_div;
        cvt_rf_t rf;
        logic [2:0] rf_cnt;
        logic refresh;
        logic vsync;
        logic vblank;
        logic vdisp;
        logic pending;
        logic irq_n;
        logic ul;
        logic cur_hit;
        logic [15:0] mem_addr;
    } cvt_state_t;

endpackage

//--- verification/cvt_display_model.sv
// monitor side model: character clock and horizontal sync pins
`timescale 1ns/1ps
module cvt_display_model (
    // clock
    input wire logic clk,
    // control from bench
    input wire logic run,
    input wire logic slow,
    // pins towards the block
    output logic hsync,
    output logic char_clk
);
    logic [6:0] cnt;
    logic [6:0] last;

    initial begin
        cnt = 7'h00;
        hsync = 1'b0;
        char_clk = 1'b0;
    end

    // line of 40 clocks, or 64 when slow
    assign last = slow ? 7'h3F : 7'h27;

    always @(posedge clk) begin
        if (!run) begin
            cnt <= 7'h00;
            hsync <= 1'b0;
            char_clk <= 1'b0;
        end else begin
            cnt <= (cnt == last) ? 7'h00 : cnt + 7'h01;
            hsync <= (cnt < 7'h04);
            char_clk <= cnt[1];
        end
    end
endmodule

//--- verification/test_cvt_crtc_vtiming.sv
// self-checking bench for the vertical timing and cursor block
`timescale 1ns/1ps
module test_cvt_crtc_vtiming;
    import cvt_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic idx_wr = 1'b0;
    logic dat_wr = 1'b0;
    logic dat_rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic twr;
    logic [7:0] twr_idx;
    logic [7:0] twr_data;
    logic [7:0] twr_mask;
    cvt_ext_t ext;
    logic hs;
    logic cc;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic vsync, vblank, vdisp, irq_n, pend, refr, ul, hit;
    logic [15:0] maddr;
    logic [15:0] cpos;
    int num_errors = 0;
    int check_count = 0;
    int lcnt = 0;
    int rcnt = 0;
    int l_vde, l_vbs, l_vss, l_vse;
    logic [7:0] d;

    always #12.5 clk = ~clk;

    cvt_crtc_vtiming dut (
        .CLK_SYS(clk), .NRST(nrst),
        .IO_INDEX_WR(idx_wr), .IO_DATA_WR(dat_wr), .IO_DATA_RD(dat_rd),
        .IO_WDATA(wdata), .IO_RDATA(rdata),
        .TIMING_WR(twr), .TIMING_WR_IDX(twr_idx),
        .TIMING_WR_DATA(twr_data), .TIMING_WR_MASK(twr_mask),
        .EXT_CFG(ext), .HSYNC_IN(hs), .CHAR_CLK_IN(cc),
        .VSYNC(vsync), .VBLANK(vblank), .VDISP(vdisp),
        .IRQ_OUT_N(irq_n), .VINT_PENDING(pend),
        .DISPLAY_MEM_ADDR(maddr), .REFRESH_REQ(refr),
        .UNDERLINE(ul), .CURSOR_HIT(hit), .CURSOR_POS(cpos)
    );

    cvt_display_model mon (
        .clk(clk), .run(run), .slow(slow), .hsync(hs), .char_clk(cc)
    );

    // line events counted from the first line of a frame
    always @(posedge hs) lcnt = lcnt + 1;
    always @(posedge vdisp) lcnt = 0;
    always @(negedge vdisp) l_vde = lcnt;
    always @(posedge vblank) l_vbs = lcnt;
    always @(posedge vsync) l_vss = lcnt;
    always @(negedge vsync) l_vse = lcnt;
    always @(posedge clk) if (refr === 1'b1) rcnt = rcnt + 1;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic sel(input logic [7:0] i);
        idx_wr = 1'b1;
        wdata = i;
        @(posedge clk);
        #1 idx_wr = 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        sel(i);
        dat_wr = 1'b1;
        wdata = v;
        @(posedge clk);
        #1 dat_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] i, output logic [7:0] v);
        sel(i);
        dat_rd = 1'b1;
        @(posedge clk);
        #1 dat_rd = 1'b0;
        v = rdata;
    endtask

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic lines_refresh(input logic [15:0] exp);
        @(posedge hs);
        rcnt = 0;
        repeat (4) @(posedge hs);
        chk(16'(rcnt), exp);
        step;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(80000 * 25);
        num_errors++;
        end_of_test;
    end

    initial begin
        // frame of 305 lines, sync lines 260 to 264
        ext = '0;
        ext.readback_en = 1'b1;
        ext.vss_hi = 2'b01;
        ext.vde_hi = 2'b01;
        ext.vbs_b8 = 1'b1;
        ext.byte_mode = 1'b1;
        ext.start_addr = 16'hA5C3;
        ext.vtotal = 10'h130;
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        step;
        for (int i = 14; i < 22; i++) begin
            rd(8'(i), d);
            chk({8'h00, d}, 16'h0000);
        end
        chk({15'h0000, irq_n}, 16'h0001);
        $display("reset values done");

        wr(8'h0E, 8'h12);
        wr(8'h0F, 8'h34);
        chk(cpos, 16'h1234);
        rd(8'h0E, d);
        chk({8'h00, d}, 16'h0012);
        $display("cursor done");

        wr(8'h10, 8'h04);
        wr(8'h11, 8'h08);
        rd(8'h10, d);
        chk({8'h00, d}, 16'h0004);
        rd(8'h11, d);
        chk({8'h00, d}, 16'h0008);
        ext.readback_en = 1'b0;
        rd(8'h10, d);
        chk({8'h00, d}, 16'h0000);
        rd(8'h11, d);
        chk({8'h00, d}, 16'h0000);
        ext.readback_en = 1'b1;
        $display("readback done");

        wr(8'h03, 8'h5A);
        chk({twr, twr_idx, twr_mask[6:0]}, {1'b1, 8'h03, 7'h7F});
        chk({8'h00, twr_data}, 16'h005A);
        wr(8'h11, 8'h88);
        wr(8'h03, 8'h11);
        chk({15'h0000, twr}, 16'h0000);
        wr(8'h07, 8'hFF);
        chk({twr, twr_idx, twr_mask}, {1'b1, 8'h07, 8'h10});
        wr(8'h11, 8'h08);
        $display("write protect done");

        wr(8'h12, 8'h00);
        wr(8'h15, 8'h02);
        wr(8'h14, 8'h00);
        wr(8'h13, 8'h08);
        wr(8'h0E, 8'hA5);
        wr(8'h0F, 8'hCB);
        run = 1'b1;
        @(posedge vdisp);
        step;
        wr(8'h11, 8'h18);
        @(posedge vdisp);
        #1;
        chk(maddr, 16'hA5C3);
        chk({15'h0000, ul}, 16'h0001);
        chk({15'h0000, hit}, 16'h0000);
        @(posedge hs);
        repeat (3) @(posedge clk);
        #1;
        chk(maddr, 16'hA5CB);
        chk({15'h0000, hit}, 16'h0001);
        @(posedge vsync);
        step;
        step;
        chk({14'h0000, pend, irq_n}, 16'h0002);
        @(negedge vsync);
        #1;
        chk(16'(l_vde), 16'd256);
        chk(16'(l_vbs), 16'd258);
        chk(16'(l_vss), 16'd260);
        chk(16'(l_vse), 16'd264);
        chk(16'(l_vse - l_vss), 16'd4);
        step;
        wr(8'h11, 8'h08);
        step;
        chk({14'h0000, pend, irq_n}, 16'h0001);
        wr(8'h11, 8'h18);
        step;
        chk({14'h0000, pend, irq_n}, 16'h0001);
        $display("frame timing done");

        lines_refresh(16'd12);
        wr(8'h11, 8'h58);
        slow = 1'b1;
        lines_refresh(16'd20);
        slow = 1'b0;
        wr(8'h11, 8'h18);
        $display("refresh done");

        ext.byte_mode = 1'b0;
        @(posedge vdisp);
        #1;
        chk(maddr, 16'h4B87);
        @(posedge hs);
        repeat (3) @(posedge clk);
        #1;
        chk(maddr, 16'h4BA7);
        @(negedge vsync);
        step;
        wr(8'h11, 8'h08);
        wr(8'h11, 8'h38);
        wr(8'h14, 8'h61);
        @(posedge vdisp);
        #1;
        chk(maddr, 16'h970E);
        chk({15'h0000, ul}, 16'h0000);
        @(posedge vsync);
        step;
        step;
        chk({14'h0000, pend, irq_n}, 16'h0003);
        $display("address modes done");
        end_of_test;
    end
endmodule

//--- verilog/cvt_crtc_vtiming.sv
// vertical timing, cursor location and address mode registers
//
// Overview of operation
// - cursor position is high byte plus low byte
// - cursor compares absolute memory address counter
// - sync start is overflow bits plus low byte
// - sync registers read back only when enabled
// - write protect blocks timing writes except LC8
// - three or five refresh cycles per line
// - interrupt disable keeps interrupt output high
// - clear bit low clears pending, rearm by one
// - sync ends when low four bits match
// - sync pulse limited to sixteen scanlines
// - display end is overflow bits plus low byte
// - pitch is nine bits with extension bit
// - next row start is previous plus pitch
// - pitch shifted left in word mode
// - doubleword mode rotates address bits 13:0 left two
// - word or byte addressing outside doubleword mode
// - count by four divides address counter clock
// - underline on selected cell scanline
// - blanking start is ten bits from three registers
`timescale 1ns/1ps
`include "cvt_defines.svh"
module cvt_crtc_vtiming (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // indexed register port
    input wire logic IO_INDEX_WR,
    input wire logic IO_DATA_WR,
    input wire logic IO_DATA_RD,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    // writes passed on to timing registers 0 to 7
    output logic TIMING_WR,
    output logic [7:0] TIMING_WR_IDX,
    output logic [7:0] TIMING_WR_DATA,
    output logic [7:0] TIMING_WR_MASK,
    // fields from neighbouring registers
    input cvt_pkg::cvt_ext_t EXT_CFG,
    // display pins
    input wire logic HSYNC_IN,
    input wire logic CHAR_CLK_IN,
    // timing outputs
    output logic VSYNC,
    output logic VBLANK,
    output logic VDISP,
    output logic IRQ_OUT_N,
    output logic VINT_PENDING,
    // memory address and text outputs
    output logic [15:0] DISPLAY_MEM_ADDR,
    output logic REFRESH_REQ,
    output logic UNDERLINE,
    output logic CURSOR_HIT,
    output logic [15:0] CURSOR_POS
);
    import cvt_pkg::*;

    cvt_state_t r;
    cvt_state_t n;
    logic [1:0] pin_s;
    logic hs_s;
    logic ch_s;
    logic hs_edge;
    logic ch_edge;
    logic [9:0] vss;
    logic [9:0] vde;
    logic [9:0] vbs;
    logic [8:0] pitch9;
    logic [15:0] pitch_eff;
    logic [9:0] nscan;
    logic frame;
    logic row_end;
    logic vs_start;
    logic wp;

    function automatic logic in_timing(input logic [7:0] i);
        in_timing = (i <= `CVT_IDX_TIMING_LAST);
    endfunction

    function automatic logic [15:0] rot_addr(input logic [15:0] c,
                                             input logic dw,
                                             input logic bm);
        if (dw) begin
            rot_addr = {c[15:14], c[11:0], c[13:12]};
        end else if (bm) begin
            rot_addr = c;
        end else begin
            rot_addr = {c[14:0], c[15]};
        end
    endfunction

    cvt_sync2 u_sync (
        .clk(CLK_SYS),
        .rst_n(NRST),
        .d({HSYNC_IN, CHAR_CLK_IN}),
        .q(pin_s)
    );

    assign hs_s = pin_s[1];
    assign ch_s = pin_s[0];
    assign hs_edge = hs_s & ~r.hs_d;
    assign ch_edge = ch_s & ~r.ch_d;

    // assembled fields
    assign vss = {EXT_CFG.vss_hi, r.regs.vss_lo};
    assign vde = {EXT_CFG.vde_hi, r.regs.vde_lo};
    assign vbs = {EXT_CFG.vbs_b9, EXT_CFG.vbs_b8, r.regs.vbs_lo};
    assign pitch9 = {EXT_CFG.pitch_b8, r.regs.pitch_lo};
    assign pitch_eff = EXT_CFG.byte_mode ? {7'h00, pitch9}
                                         : {6'h00, pitch9, 1'b0};
    assign wp = r.regs.vse_ctl[`CVT_VSE_WPROT];
    assign nscan = (r.scan == EXT_CFG.vtotal) ? 10'h000
                                               : r.scan + 10'h001;

    always_comb begin
        n = r;
        frame = 1'b0;
        row_end = 1'b0;
        vs_start = 1'b0;
        n.twr = 1'b0;
        n.refresh = 1'b0;
        n.hs_d = hs_s;
        n.ch_d = ch_s;

        // register port
        if (IO_DATA_WR) begin
            case (r.idx)
                `CVT_IDX_CUR_HI: begin
                    n.regs.cur_hi = IO_WDATA;
                end
                `CVT_IDX_CUR_LO: begin
                    n.regs.cur_lo = IO_WDATA;
                end
                `CVT_IDX_VSS_LO: begin
                    n.regs.vss_lo = IO_WDATA;
                end
                `CVT_IDX_VSE_CTL: begin
                    n.regs.vse_ctl = IO_WDATA;
                end
                `CVT_IDX_VDE_LO: begin
                    n.regs.vde_lo = IO_WDATA;
                end
                `CVT_IDX_PITCH_LO: begin
                    n.regs.pitch_lo = IO_WDATA;
                end
                `CVT_IDX_UL_MODE: begin
                    n.regs.ul_mode = IO_WDATA;
                end
                `CVT_IDX_VBS_LO: begin
                    n.regs.vbs_lo = IO_WDATA;
                end
                default: begin
                    n.regs = r.regs;
                end
            endcase
            if (in_timing(r.idx) && (!wp ||
                r.idx == `CVT_IDX_OVERFLOW)) begin
                n.twr = 1'b1;
                n.twr_idx = r.idx;
                n.twr_data = IO_WDATA;
                n.twr_mask = wp ? `CVT_MASK_LC8 : `CVT_MASK_ALL;
            end
        end
        if (IO_INDEX_WR) begin
            n.idx = IO_WDATA;
        end
        if (IO_DATA_RD) begin
            case (r.idx)
                `CVT_IDX_CUR_HI: begin
                    n.rdata = r.regs.cur_hi;
                end
                `CVT_IDX_CUR_LO: begin
                    n.rdata = r.regs.cur_lo;
                end
                `CVT_IDX_VSS_LO: begin
                    n.rdata = EXT_CFG.readback_en ? r.regs.vss_lo
                                                  : `CVT_RD_NONE;
                end
                `CVT_IDX_VSE_CTL: begin
                    n.rdata = EXT_CFG.readback_en ? r.regs.vse_ctl
                                                  : `CVT_RD_NONE;
                end
                `CVT_IDX_VDE_LO: begin
                    n.rdata = r.regs.vde_lo;
                end
                `CVT_IDX_PITCH_LO: begin
                    n.rdata = r.regs.pitch_lo;
                end
                `CVT_IDX_UL_MODE: begin
                    n.rdata = r.regs.ul_mode;
                end
                `CVT_IDX_VBS_LO: begin
                    n.rdata = r.regs.vbs_lo;
                end
                default: begin
                    n.rdata = `CVT_RD_NONE;
                end
            endcase
        end

        // character clock: address counter and refresh
        if (ch_edge) begin
            n.ma_div = r.ma_div + 2'h1;
            if (!r.regs.ul_mode[`CVT_UL_CNT4] ||
                r.ma_div == `CVT_MA_DIV_LAST) begin
                n.ma_cnt = r.ma_cnt + 16'h0001;
            end
        end
        case (r.rf)
            CVT_RF_IDLE: begin
                n.rf = CVT_RF_IDLE;
            end
            CVT_RF_RUN: begin
                if (ch_edge) begin
                    n.refresh = 1'b1;
                    n.rf_cnt = r.rf_cnt - 3'h1;
                    if (r.rf_cnt == 3'h1) begin
                        n.rf = CVT_RF_IDLE;
                    end
                end
            end
            default: begin
                n.rf = CVT_RF_IDLE;
            end
        endcase

        // horizontal sync: next scanline
        if (hs_edge) begin
            n.scan = nscan;
            frame = (nscan == 10'h000);
            n.rf = CVT_RF_RUN;
            n.rf_cnt = r.regs.vse_ctl[`CVT_VSE_REFRESH] ? `CVT_REFRESH_HI
                                                       : `CVT_REFRESH_LO;
            if (frame) begin
                n.cell_row = 5'h00;
                n.vdisp = 1'b1;
                n.vblank = 1'b0;
                n.row_start = EXT_CFG.start_addr;
            end else begin
                if (r.cell_row == EXT_CFG.cell_height) begin
                    n.cell_row = 5'h00;
                    row_end = 1'b1;
                end else begin
                    n.cell_row = r.cell_row + 5'h01;
                end
                if (nscan == vde) begin
                    n.vdisp = 1'b0;
                end
                if (nscan == vbs) begin
                    n.vblank = 1'b1;
                end
                if (row_end) begin
                    n.row_start = r.row_start + pitch_eff;
                end
            end
            n.ma_cnt = n.row_start;
            n.ma_div = 2'h0;
            if (nscan == vss) begin
                n.vsync = 1'b1;
                vs_start = 1'b1;
            end else if (r.vsync &&
                nscan[3:0] == r.regs.vse_ctl[3:0]) begin
                n.vsync = 1'b0;
            end
        end

        // vertical interrupt; a held clear bit keeps the flag low
        if (vs_start && r.regs.vse_ctl[`CVT_VSE_IRQ_CLR]) begin
            n.pending = 1'b1;
        end
        if (!n.regs.vse_ctl[`CVT_VSE_IRQ_CLR]) begin
            n.pending = 1'b0;
        end
        n.irq_n = ~(n.pending &
                    ~n.regs.vse_ctl[`CVT_VSE_IRQ_DIS]);

        // text and address outputs
        n.ul = (n.cell_row == n.regs.ul_mode[4:0]);
        n.cur_hit = (n.ma_cnt == {n.regs.cur_hi, n.regs.cur_lo});
        n.mem_addr = rot_addr(n.ma_cnt,
                              n.regs.ul_mode[`CVT_UL_DWORD],
                              EXT_CFG.byte_mode);
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            r <= '0;
            r.regs <= {8{`CVT_REG_RESET}};
            r.irq_n <= 1'b1;
            r.rf <= CVT_RF_IDLE;
            // zero row and counter match zero fields
            r.ul <= 1'b1;
            r.cur_hit <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign IO_RDATA = r.rdata;
    assign TIMING_WR = r.twr;
    assign TIMING_WR_IDX = r.twr_idx;
    assign TIMING_WR_DATA = r.twr_data;
    assign TIMING_WR_MASK = r.twr_mask;
    assign VSYNC = r.vsync;
    assign VBLANK = r.vblank;
    assign VDISP = r.vdisp;
    assign IRQ_OUT_N = r.irq_n;
    assign VINT_PENDING = r.pending;
    assign DISPLAY_MEM_ADDR = r.mem_addr;
    assign REFRESH_REQ = r.refresh;
    assign UNDERLINE = r.ul;
    assign CURSOR_HIT = r.cur_hit;
    assign CURSOR_POS = {r.regs.cur_hi, r.regs.cur_lo};

    // helper: scanlines spent in vertical sync
    logic [4:0] vs_lines_r;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            vs_lines_r <= 5'h00;
        end else if (!r.vsync) begin
            vs_lines_r <= 5'h00;
        end else if (hs_edge && vs_lines_r != 5'h1F) begin
            vs_lines_r <= vs_lines_r + 5'h01;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    sequence s_data_read(logic [7:0] i);
        IO_DATA_RD && r.idx == i && !EXT_CFG.readback_en;
    endsequence

    sequence s_line_start;
        hs_edge && nscan == vss;
    endsequence

    a_cursor_word: assert property (
        CURSOR_POS == {r.regs.cur_hi, r.regs.cur_lo} &&
        (CURSOR_HIT == (r.ma_cnt == CURSOR_POS)))
        else $error("cursor position or match wrong");

    a_sync_start: assert property (
        s_line_start |=> VSYNC && r.scan == vss)
        else $error("sync did not start on start line");

    a_sync_readback: assert property (
        s_data_read(`CVT_IDX_VSS_LO) or s_data_read(`CVT_IDX_VSE_CTL)
        |=> IO_RDATA == `CVT_RD_NONE)
        else $error("write-only sync register read back");

    a_wprot_block: assert property (
        IO_DATA_WR && wp && in_timing(r.idx) &&
        r.idx != `CVT_IDX_OVERFLOW |=> !TIMING_WR)
        else $error("protected timing write passed");

    a_wprot_lc8: assert property (
        IO_DATA_WR && wp && r.idx == `CVT_IDX_OVERFLOW
        |=> TIMING_WR && TIMING_WR_MASK == `CVT_MASK_LC8)
        else $error("overflow bit 8 write lost");

    a_refresh_load: assert property (
        hs_edge |=> r.rf == CVT_RF_RUN && r.rf_cnt ==
        ($past(r.regs.vse_ctl[`CVT_VSE_REFRESH]) ? 3'h5 : 3'h3))
        else $error("refresh count wrong");

    a_irq_disable: assert property (
        r.regs.vse_ctl[`CVT_VSE_IRQ_DIS] |-> IRQ_OUT_N)
        else $error("interrupt asserted while disabled");

    a_irq_clear: assert property (
        !r.regs.vse_ctl[`CVT_VSE_IRQ_CLR] |-> !VINT_PENDING && IRQ_OUT_N)
        else $error("clear bit did not clear interrupt");

    a_irq_at_sync: assert property (
        s_line_start and (r.regs.vse_ctl[`CVT_VSE_IRQ_CLR] && !IO_DATA_WR)
        |=> VINT_PENDING && VSYNC)
        else $error("interrupt not raised at sync start");

    a_sync_end: assert property (
        $fell(VSYNC) |-> r.scan[3:0] == r.regs.vse_ctl[3:0])
        else $error("sync ended off the match line");

    a_sync_width: assert property (
        vs_lines_r <= `CVT_VSYNC_MAX_LINES)
        else $error("sync pulse too long");

    a_dword_rotate: assert property (
        r.regs.ul_mode[`CVT_UL_DWORD] && $stable(r.regs.ul_mode)
        |-> DISPLAY_MEM_ADDR[1:0] == r.ma_cnt[13:12])
        else $error("doubleword rotation wrong");

    a_underline_row: assert property (
        $stable(r.regs.ul_mode) |->
        UNDERLINE == (r.cell_row == r.regs.ul_mode[4:0]))
        else $error("underline on wrong row");
endmodule

//--- verilog/cvt_sync2.sv
// two-stage synchroniser for the display pins
`timescale 1ns/1ps
module cvt_sync2 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, synchronised out
    input wire logic [1:0] d,
    output logic [1:0] q
);
    logic [1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 2'h0;
            q <= 2'h0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
